// ---- verilog/acl_pkg.sv ----
// =====================================================================
// Purpose: Shared constants and types for the ACL table access window
// Assumes: One port's window, 8-bit registers, 16-bit byte addresses
// Notes:   Offsets are the low 12 address bits; the top nibble is the port

package acl_pkg;

	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned IDX_W      = 4;
	localparam int unsigned ENTRIES    = 16;
	localparam int unsigned HELD_BYTES = 5;
	localparam int unsigned BE_W       = 16;
	localparam int unsigned FWD_MAP_W  = 6;

	localparam logic [3:0] PORT_NUM_DEF = 4'h1;

	// =================================================================
	// Register offsets
	localparam logic [11:0] OFF_REMARK_MAP = 12'h60b;
	localparam logic [11:0] OFF_SPARE      = 12'h60c;
	localparam logic [11:0] OFF_FWD_MAP    = 12'h60d;
	localparam logic [11:0] OFF_RULE_HI    = 12'h60e;
	localparam logic [11:0] OFF_RULE_LO    = 12'h60f;
	localparam logic [11:0] OFF_BSEL_HI    = 12'h610;
	localparam logic [11:0] OFF_BSEL_LO    = 12'h611;
	localparam logic [11:0] OFF_CTRL       = 12'h612;

	// =================================================================
	// Field positions
	localparam int unsigned REMARK_LSB_BIT = 7;
	localparam int unsigned MAP_MODE_LSB   = 5;
	localparam int unsigned CTRL_WR_DONE   = 6;
	localparam int unsigned CTRL_RD_DONE   = 5;
	localparam int unsigned CTRL_DIR       = 4;
	// Held staging bytes: slot 0 is the remark/map byte, slot 4 the last
	localparam int unsigned SLOT_REMARK    = 0;
	localparam int unsigned SLOT_FWD       = 2;
	localparam int unsigned SLOT_RULE_HI   = 3;
	localparam int unsigned SLOT_RULE_LO   = 4;

	// =================================================================
	// Reset values
	localparam logic [7:0]       STAGE_RST = 8'h00;
	localparam logic [7:0]       BSEL_RST  = 8'h00;
	localparam logic             DONE_RST  = 1'b1;
	localparam logic             DIR_RST   = 1'b0;
	localparam logic [IDX_W-1:0] IDX_RST   = 4'h0;

	typedef logic [HELD_BYTES*8-1:0] entry_t;

	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_FINISH = 2'b11
	} xfer_state_t;

endpackage

// ---- verilog/acl_table_if.sv ----
// =====================================================================
// Purpose: Carrier between the register window and the entry table
// Assumes: Same clock on both sides
// Notes:   Read data and lookup data are registered inside the table

`timescale 1ns/100ps

interface acl_table_if;
	logic [acl_pkg::IDX_W-1:0]      rd_idx;
	acl_pkg::entry_t                rd_data;
	logic                           wr_en;
	logic [acl_pkg::IDX_W-1:0]      wr_idx;
	acl_pkg::entry_t                wr_data;
	logic [acl_pkg::HELD_BYTES-1:0] wr_be;
	logic [acl_pkg::IDX_W-1:0]      lk_idx;
	acl_pkg::entry_t                lk_data;

	modport mem (input rd_idx, wr_en, wr_idx, wr_data, wr_be, lk_idx,
		output rd_data, lk_data);
	modport ctl (output rd_idx, wr_en, wr_idx, wr_data, wr_be, lk_idx,
		input rd_data, lk_data);
endinterface // acl_table_if

// ---- verilog/acl_entry_table.sv ----
// =====================================================================
// Purpose: Sixteen rule entries with byte-masked write and two read ports
// Assumes: Transfer read and lookup read both take one cycle
// Notes:   A lookup of an entry being written sees the old value once

`timescale 1ns/100ps

module acl_entry_table
(
	input wire logic     i_clk,   // System clock
	input wire logic     i_rst_b, // Asynchronous reset, active low
	acl_table_if.mem     tbl      // Table access port
);

	acl_pkg::entry_t mem_reg [acl_pkg::ENTRIES];

	// =================================================================
	// Storage; bytes without their enable keep their old value
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			for (int e = 0; e < acl_pkg::ENTRIES; e++)
				mem_reg[e] <= '0;
		end
		else if (tbl.wr_en)
		begin
			for (int b = 0; b < acl_pkg::HELD_BYTES; b++)
				if (tbl.wr_be[b])
					mem_reg[tbl.wr_idx][b*8 +: 8] <= tbl.wr_data[b*8 +: 8];
		end
	end

	// =================================================================
	// Registered read ports
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tbl.rd_data <= '0;
			tbl.lk_data <= '0;
		end
		else
		begin
			tbl.rd_data <= mem_reg[tbl.rd_idx];
			tbl.lk_data <= mem_reg[tbl.lk_idx];
		end
	end

endmodule // acl_entry_table

// ---- verilog/acl_table_indirect_access.sv ----
// =====================================================================
// Purpose: Per-port indirect access window onto the ACL rule table
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Staging bytes 0..A live outside; this block holds bytes B..F
//
// How it works
// - Bit 7 of the remark/map byte is the remark priority LSB.
// - Remark priority MSBs come from outside and join the LSB.
// - Forward map bit 0 is port 1; set bit forwards, clear withholds.
// - High select bit 0 covers staging byte 7, bit 7 byte 0.
// - Low select bit 0 covers staging byte F, bit 7 byte 8.
// - Only bytes whose select bit is one take part in a transfer.
// - Writing the low select starts a transfer when idle; control bit 4 picks write.
// - Write status reads 0 during a write, 1 when done; resets 1.
// - Read status reads 0 during a read, 1 when done; resets 1.

`timescale 1ns/100ps

module acl_table_indirect_access #(
	parameter logic [3:0] PORT_NUM = acl_pkg::PORT_NUM_DEF // Address nibble
) (
	input  wire logic        I_REF_CLK,            // 250 MHz clock
	input  wire logic        I_RST_B,              // Async reset, low
	input  wire logic [15:0] I_ADDR,               // Register byte address
	input  wire logic [7:0]  I_WDATA,              // Write data
	input  wire logic        I_WR,                 // Write strobe
	input  wire logic        I_RD,                 // Read strobe
	output logic      [7:0]  O_RDATA,              // Read data, next cycle
	input  wire logic [3:0]  I_LOOKUP_IDX,         // Matched entry
	input  wire logic [1:0]  I_LOOKUP_REMARK_MSB,  // Remark bits 2:1 of it
	output logic      [5:0]  O_LOOKUP_FWD_MAP,     // Bit 0 is port 1
	output logic      [1:0]  O_LOOKUP_MAP_MODE,    // Entry map mode
	output logic      [2:0]  O_LOOKUP_REMARK_PRIO, // Full remark value
	output logic      [15:0] O_LOOKUP_RULESET,     // Entry ruleset
	output logic             O_XFER_START,         // Transfer start pulse
	output logic             O_XFER_WRITE,         // Transfer is a write
	output logic      [3:0]  O_XFER_INDEX,         // Transfer entry
	output logic      [15:0] O_XFER_BYTE_EN,       // Bit k enables byte k
	output logic             O_BUSY                // Transfer running
);

	localparam int unsigned NB = acl_pkg::HELD_BYTES;

	acl_table_if tbl_if ();

	acl_pkg::xfer_state_t  state_reg;
	acl_pkg::xfer_state_t  state_next;
	logic [7:0]            stage_reg [NB];
	logic [7:0]            bsel_hi_reg;
	logic [7:0]            bsel_lo_reg;
	logic                  dir_reg;
	logic [3:0]            idx_reg;
	logic                  wr_done_reg;
	logic                  rd_done_reg;
	logic [15:0]           op_be_reg;
	logic [1:0]            msb_reg;
	logic [7:0]            rdata_next;
	logic                  hit;
	logic [11:0]           off;
	logic                  start;
	logic                  copy_in;

	// =================================================================
	// Address decode
	assign hit   = (I_ADDR[15:12] == PORT_NUM);
	assign off   = I_ADDR[11:0];
	assign start = I_WR && hit && (off == acl_pkg::OFF_BSEL_LO)
		&& (state_reg == acl_pkg::ST_IDLE);
	assign copy_in = (state_reg == acl_pkg::ST_FINISH) && !O_XFER_WRITE;
	assign O_BUSY  = (state_reg != acl_pkg::ST_IDLE);

	// =================================================================
	// Table
	acl_entry_table acl_entry_table_inst
	(
		.i_clk   (I_REF_CLK),
		.i_rst_b (I_RST_B),
		.tbl     (tbl_if.mem)
	);

	assign tbl_if.rd_idx = O_XFER_INDEX;
	assign tbl_if.wr_idx = O_XFER_INDEX;
	assign tbl_if.wr_en  = (state_reg == acl_pkg::ST_ACCESS) && O_XFER_WRITE;
	assign tbl_if.wr_be  = op_be_reg[NB-1:0];
	assign tbl_if.lk_idx = I_LOOKUP_IDX;

	always_comb
	begin
		tbl_if.wr_data = '0;
		for (int i = 0; i < NB; i++)
			tbl_if.wr_data[(NB-1-i)*8 +: 8] = stage_reg[i];
	end

	// =================================================================
	// Transfer sequencer: one cycle at the table, one to return
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			acl_pkg::ST_IDLE:
				if (start)
					state_next = acl_pkg::ST_ACCESS;
			acl_pkg::ST_ACCESS:
				state_next = acl_pkg::ST_FINISH;
			acl_pkg::ST_FINISH:
				state_next = acl_pkg::ST_IDLE;
			default:
				state_next = acl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			state_reg <= acl_pkg::ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Direction, index and enables are frozen at the start so that
	// software may set up the next transfer while this one runs
	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			O_XFER_START <= 1'b0;
			O_XFER_WRITE <= acl_pkg::DIR_RST;
			O_XFER_INDEX <= acl_pkg::IDX_RST;
			op_be_reg    <= '0;
		end
		else
		begin
			O_XFER_START <= start;
			if (start)
			begin
				O_XFER_WRITE <= dir_reg;
				O_XFER_INDEX <= idx_reg;
				op_be_reg    <= {bsel_hi_reg, I_WDATA};
			end
		end
	end

	// Bit k of the outgoing enable is staging byte k, so the
	// select registers are bit-reversed
	always_comb
	begin
		for (int k = 0; k < 16; k++)
			O_XFER_BYTE_EN[k] = op_be_reg[15-k];
	end

	// =================================================================
	// Status flags; only one transfer runs, so set and clear never meet
	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			wr_done_reg <= acl_pkg::DONE_RST;
			rd_done_reg <= acl_pkg::DONE_RST;
		end
		else if (start)
		begin
			if (dir_reg)
				wr_done_reg <= 1'b0;
			else
				rd_done_reg <= 1'b0;
		end
		else if (state_reg == acl_pkg::ST_FINISH)
		begin
			if (O_XFER_WRITE)
				wr_done_reg <= 1'b1;
			else
				rd_done_reg <= 1'b1;
		end
	end

	// =================================================================
	// Control and select registers
	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			bsel_hi_reg <= acl_pkg::BSEL_RST;
			bsel_lo_reg <= acl_pkg::BSEL_RST;
			dir_reg     <= acl_pkg::DIR_RST;
			idx_reg     <= acl_pkg::IDX_RST;
		end
		else if (I_WR && hit)
		begin
			if (off == acl_pkg::OFF_BSEL_HI)
				bsel_hi_reg <= I_WDATA;
			if (off == acl_pkg::OFF_BSEL_LO)
				bsel_lo_reg <= I_WDATA;
			if (off == acl_pkg::OFF_CTRL)
			begin
				dir_reg <= I_WDATA[acl_pkg::CTRL_DIR];
				idx_reg <= I_WDATA[3:0];
			end
		end
	end

	// =================================================================
	// Staging bytes; a returning read beats a software write to the
	// same byte, which is why software must wait for read status
	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			for (int i = 0; i < NB; i++)
				stage_reg[i] <= acl_pkg::STAGE_RST;
		end
		else
		begin
			for (int i = 0; i < NB; i++)
			begin
				if (copy_in && op_be_reg[NB-1-i])
					stage_reg[i] <= tbl_if.rd_data[(NB-1-i)*8 +: 8];
				else if (I_WR && hit && off == acl_pkg::OFF_REMARK_MAP + 12'(i))
					stage_reg[i] <= I_WDATA;
			end
		end
	end

	// =================================================================
	// Register read port; unmapped offsets read zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (I_RD && hit)
		begin
			unique case (off)
				acl_pkg::OFF_REMARK_MAP:
					rdata_next = stage_reg[acl_pkg::SLOT_REMARK];
				acl_pkg::OFF_SPARE:
					rdata_next = stage_reg[1];
				acl_pkg::OFF_FWD_MAP:
					rdata_next = stage_reg[acl_pkg::SLOT_FWD];
				acl_pkg::OFF_RULE_HI:
					rdata_next = stage_reg[acl_pkg::SLOT_RULE_HI];
				acl_pkg::OFF_RULE_LO:
					rdata_next = stage_reg[acl_pkg::SLOT_RULE_LO];
				acl_pkg::OFF_BSEL_HI:
					rdata_next = bsel_hi_reg;
				acl_pkg::OFF_BSEL_LO:
					rdata_next = bsel_lo_reg;
				acl_pkg::OFF_CTRL:
					rdata_next = {1'b0, wr_done_reg, rd_done_reg, dir_reg, idx_reg};
				default:
					rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			O_RDATA <= 8'h00;
		else
			O_RDATA <= rdata_next;
	end

	// =================================================================
	// Lookup results for the matching datapath
	always_ff @(posedge I_REF_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			msb_reg <= 2'b00;
		else
			msb_reg <= I_LOOKUP_REMARK_MSB;
	end

	assign O_LOOKUP_REMARK_PRIO = {msb_reg, tbl_if.lk_data[39]};
	assign O_LOOKUP_MAP_MODE    = tbl_if.lk_data[38:37];
	assign O_LOOKUP_FWD_MAP     = tbl_if.lk_data[21:16];
	assign O_LOOKUP_RULESET     = tbl_if.lk_data[15:0];

	// =================================================================
	// Checks
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_B);

	logic wr_b;
	logic rd_b;
	logic wr_f;
	assign wr_b = I_WR && hit && (off == acl_pkg::OFF_REMARK_MAP);
	assign rd_b = I_RD && hit && (off == acl_pkg::OFF_REMARK_MAP);
	assign wr_f = I_WR && hit && (off == acl_pkg::OFF_RULE_LO);

	AST_REMARK_LSB: assert property (
		(wr_b && state_reg != acl_pkg::ST_FINISH) ##1 rd_b
		|=> O_RDATA[7] == $past(I_WDATA[7], 2))
		else $error("remark lsb not held in bit 7");

	AST_REMARK_MSB: assert property (
		O_LOOKUP_REMARK_PRIO[2:1] == $past(I_LOOKUP_REMARK_MSB))
		else $error("remark msb not joined");

	AST_FWD_MAP: assert property (
		(state_reg == acl_pkg::ST_FINISH && O_XFER_WRITE && op_be_reg[2]
		&& I_LOOKUP_IDX == O_XFER_INDEX)
		|=> O_LOOKUP_FWD_MAP == $past(stage_reg[acl_pkg::SLOT_FWD][5:0], 2))
		else $error("forward map not written to entry");

	AST_BSEL_HI: assert property (
		start |=> O_XFER_BYTE_EN[0] == $past(bsel_hi_reg[7])
		&& O_XFER_BYTE_EN[7] == $past(bsel_hi_reg[0]))
		else $error("high select order wrong");

	AST_BSEL_LO: assert property (
		start |=> O_XFER_BYTE_EN[15] == $past(I_WDATA[0])
		&& O_XFER_BYTE_EN[8] == $past(I_WDATA[7]))
		else $error("low select order wrong");

	AST_MASKED_KEEP: assert property (
		(copy_in && !op_be_reg[0] && !wr_f)
		|=> $stable(stage_reg[acl_pkg::SLOT_RULE_LO]))
		else $error("masked byte changed by read");

	AST_START_SEQ: assert property (
		start |=> state_reg == acl_pkg::ST_ACCESS && O_XFER_WRITE == $past(dir_reg)
		##1 state_reg == acl_pkg::ST_FINISH ##1 state_reg == acl_pkg::ST_IDLE)
		else $error("transfer sequence wrong");

	AST_WR_STATUS: assert property (
		(start && dir_reg) |=> !wr_done_reg [*2] ##1 wr_done_reg)
		else $error("write status timing wrong");

	AST_RD_STATUS: assert property (
		(start && !dir_reg) |=> !rd_done_reg [*2] ##1 rd_done_reg)
		else $error("read status timing wrong");

	AST_INDEX: assert property (
		start |=> O_XFER_INDEX == $past(idx_reg) && tbl_if.rd_idx == O_XFER_INDEX)
		else $error("index not taken");

	AST_READ_COPY: assert property (
		(copy_in && op_be_reg[4])
		|=> stage_reg[acl_pkg::SLOT_REMARK] == $past(tbl_if.rd_data[39:32]))
		else $error("enabled byte not copied");

	COV_READ: cover property (start && !dir_reg ##3 rd_done_reg);
	COV_WRITE: cover property (start && dir_reg ##3 wr_done_reg);
	COV_REFUSED: cover property (O_BUSY && I_WR && hit && off == acl_pkg::OFF_BSEL_LO);

endmodule // acl_table_indirect_access

// ---- test/acl_table_indirect_access_tb.sv ----
// =====================================================================
// Purpose: Self-checking bench for the ACL table access window
// Assumes: Default port nibble 1; the bench drives every input itself
// Notes:   Integer model of the held staging bytes and sixteen entries

`timescale 1ns/100ps

module acl_table_indirect_access_tb;
	logic        I_REF_CLK           = 1'b0;
	logic        I_RST_B             = 1'b0;
	logic [15:0] I_ADDR              = 16'h0000;
	logic [7:0]  I_WDATA             = 8'h00;
	logic        I_WR                = 1'b0;
	logic        I_RD                = 1'b0;
	logic [3:0]  I_LOOKUP_IDX        = 4'h0;
	logic [1:0]  I_LOOKUP_REMARK_MSB = 2'h0;
	logic [7:0]  O_RDATA;
	logic [5:0]  O_LOOKUP_FWD_MAP;
	logic [1:0]  O_LOOKUP_MAP_MODE;
	logic [2:0]  O_LOOKUP_REMARK_PRIO;
	logic [15:0] O_LOOKUP_RULESET;
	logic        O_XFER_START;
	logic        O_XFER_WRITE;
	logic [3:0]  O_XFER_INDEX;
	logic [15:0] O_XFER_BYTE_EN;
	logic        O_BUSY;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          stg[5];
	int          mem[16][5];
	int          bhi;
	int          blo;

	acl_table_indirect_access acl_table_indirect_access_inst
	(
		.I_REF_CLK            (I_REF_CLK),
		.I_RST_B              (I_RST_B),
		.I_ADDR               (I_ADDR),
		.I_WDATA              (I_WDATA),
		.I_WR                 (I_WR),
		.I_RD                 (I_RD),
		.O_RDATA              (O_RDATA),
		.I_LOOKUP_IDX         (I_LOOKUP_IDX),
		.I_LOOKUP_REMARK_MSB  (I_LOOKUP_REMARK_MSB),
		.O_LOOKUP_FWD_MAP     (O_LOOKUP_FWD_MAP),
		.O_LOOKUP_MAP_MODE    (O_LOOKUP_MAP_MODE),
		.O_LOOKUP_REMARK_PRIO (O_LOOKUP_REMARK_PRIO),
		.O_LOOKUP_RULESET     (O_LOOKUP_RULESET),
		.O_XFER_START         (O_XFER_START),
		.O_XFER_WRITE         (O_XFER_WRITE),
		.O_XFER_INDEX         (O_XFER_INDEX),
		.O_XFER_BYTE_EN       (O_XFER_BYTE_EN),
		.O_BUSY               (O_BUSY)
	);

	always #2 I_REF_CLK = ~I_REF_CLK;

	// =================================================================
	// Reporting
	task automatic stop_test;
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// =================================================================
	// Register bus
	task automatic wr(input logic [11:0] a, input int d, input logic [3:0] p = 4'h1);
		@(posedge I_REF_CLK);
		I_ADDR  <= {p, a};
		I_WDATA <= d[7:0];
		I_WR    <= 1'b1;
		@(posedge I_REF_CLK);
		I_WR    <= 1'b0;
	endtask

	task automatic rc(input string w, input logic [11:0] a, input int e, input logic [3:0] p = 4'h1);
		@(posedge I_REF_CLK);
		I_ADDR <= {p, a};
		I_RD   <= 1'b1;
		@(posedge I_REF_CLK);
		I_RD   <= 1'b0;
		#1 chk(w, 16'(e[7:0]), 16'(O_RDATA));
	endtask

	// Select registers list staging bytes in reverse order
	function automatic logic [15:0] be_exp(input int h, input int l);
		for (int k = 0; k < 8; k++)
		begin
			be_exp[k]     = h[7-k];
			be_exp[k + 8] = l[7-k];
		end
	endfunction

	// =================================================================
	// One table transfer; refuse adds a start attempt while still busy
	task automatic xfer(input int w, input int ix, input int h, input int l, input bit refuse);
		wr(acl_pkg::OFF_CTRL, {w[0], ix[3:0]});
		wr(acl_pkg::OFF_BSEL_HI, h);
		bhi = h;
		@(posedge I_REF_CLK);
		I_ADDR  <= {4'h1, acl_pkg::OFF_BSEL_LO};
		I_WDATA <= l[7:0];
		I_WR    <= 1'b1;
		@(posedge I_REF_CLK);
		I_WR    <= 1'b0;
		I_ADDR  <= {4'h1, acl_pkg::OFF_CTRL};
		I_RD    <= 1'b1;
		#1 chk("start", 16'h1, 16'(O_XFER_START));
		chk("busy c1", 16'h1, 16'(O_BUSY));
		chk("xfer write", 16'(w[0]), 16'(O_XFER_WRITE));
		chk("xfer index", 16'(ix[3:0]), 16'(O_XFER_INDEX));
		chk("xfer byte en", be_exp(h, l), O_XFER_BYTE_EN);
		@(posedge I_REF_CLK);
		I_RD <= 1'b0;
		if (refuse)
		begin
			I_ADDR  <= {4'h1, acl_pkg::OFF_BSEL_LO};
			I_WDATA <= ~l[7:0];
			I_WR    <= 1'b1;
		end
		#1 chk("status busy", 16'((w[0] ? 8'h30 : 8'h40) | ix[3:0]), 16'(O_RDATA));
		chk("start c2", 16'h0, 16'(O_XFER_START));
		chk("busy c2", 16'h1, 16'(O_BUSY));
		@(posedge I_REF_CLK);
		I_WR <= 1'b0;
		#1 chk("busy c3", 16'h0, 16'(O_BUSY));
		chk("refused start", 16'h0, 16'(O_XFER_START));
		blo = refuse ? (~l & 8'hff) : (l & 8'hff);
		for (int s = 0; s < 5; s++)
			if (l[4-s])
			begin
				if (w[0])
					mem[ix][s] = stg[s];
				else
					stg[s] = mem[ix][s];
			end
		rc("status done", acl_pkg::OFF_CTRL, 8'h60 | (w[0] << 4) | ix[3:0]);
		chk("byte en held", be_exp(h, l), O_XFER_BYTE_EN);
	endtask

	task automatic look(input int ix);
		logic [1:0] m;
		m = 2'($urandom);
		@(posedge I_REF_CLK);
		I_LOOKUP_IDX        <= ix[3:0];
		I_LOOKUP_REMARK_MSB <= m;
		@(posedge I_REF_CLK);
		#1 chk("fwd map", 16'(mem[ix][2] & 8'h3f), 16'(O_LOOKUP_FWD_MAP));
		chk("map mode", 16'((mem[ix][0] >> 5) & 3), 16'(O_LOOKUP_MAP_MODE));
		chk("remark", 16'({m, mem[ix][0][7]}), 16'(O_LOOKUP_REMARK_PRIO));
		chk("ruleset", 16'({mem[ix][3][7:0], mem[ix][4][7:0]}), O_LOOKUP_RULESET);
	endtask

	task automatic stage_all;
		for (int s = 0; s < 5; s++)
		begin
			stg[s] = $urandom & 8'hff;
			wr(acl_pkg::OFF_REMARK_MAP + 12'(s), stg[s]);
		end
	endtask

	task automatic read_stage;
		for (int s = 0; s < 5; s++)
			rc("staging", acl_pkg::OFF_REMARK_MAP + 12'(s), stg[s]);
	endtask

	// =================================================================
	// Main sequence
	initial
	begin
		int v;
		void'($urandom(32'h5fe6));
		repeat (12) @(posedge I_REF_CLK);
		I_RST_B <= 1'b1;
		#1 chk("reset busy", 16'h0, 16'(O_BUSY));
		for (int a = 0; a < 7; a++)
			rc("reset value", acl_pkg::OFF_REMARK_MAP + 12'(a), 0);
		rc("reset ctrl", acl_pkg::OFF_CTRL, 8'h60);
		@(posedge I_REF_CLK);
		#1 chk("rdata idle", 16'h0, 16'(O_RDATA));
		look(5);
		// Unmapped offset and a foreign port nibble are both dead
		v = $urandom & 8'hff;
		wr(acl_pkg::OFF_BSEL_HI, v);
		wr(acl_pkg::OFF_BSEL_HI, ~v, 4'h2);
		rc("foreign write", acl_pkg::OFF_BSEL_HI, v);
		rc("foreign read", acl_pkg::OFF_BSEL_HI, 0, 4'h2);
		rc("unmapped", 12'h613, 0);
		wr(acl_pkg::OFF_CTRL, 8'hff);
		rc("ctrl ro bits", acl_pkg::OFF_CTRL, 8'h7f);
		stage_all();
		read_stage();
		// Remark byte written and read back with no gap between strobes
		v = $urandom & 8'hff;
		stg[0] = v;
		@(posedge I_REF_CLK);
		I_ADDR  <= {4'h1, acl_pkg::OFF_REMARK_MAP};
		I_WDATA <= v[7:0];
		I_WR    <= 1'b1;
		@(posedge I_REF_CLK);
		I_WR    <= 1'b0;
		I_RD    <= 1'b1;
		@(posedge I_REF_CLK);
		I_RD    <= 1'b0;
		#1 chk("remark b2b", 16'(v[7:0]), 16'(O_RDATA));
		// Lookup parked on the entry about to be written, then checked after the write
		look(9);
		// Full write then full read back into cleared staging
		xfer(1, 9, 8'h00, 8'h1f, 1'b0);
		look(9);
		for (int s = 0; s < 5; s++)
		begin
			stg[s] = 0;
			wr(acl_pkg::OFF_REMARK_MAP + 12'(s), 0);
		end
		xfer(0, 9, 8'hff, 8'hff, 1'b0);
		read_stage();
		for (int i = 0; i < 14; i++)
		begin
			stage_all();
			xfer(i & 1, $urandom % 4, $urandom & 8'hff, $urandom & 8'hff, i == 4);
			rc("select low", acl_pkg::OFF_BSEL_LO, blo);
			rc("select high", acl_pkg::OFF_BSEL_HI, bhi);
			read_stage();
			look($urandom % 4);
		end
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge I_REF_CLK);
		n_errors++;
		stop_test();
	end
endmodule // acl_table_indirect_access_tb
